// file: core/alu_exec_unit.sv
// Execution unit for subtract, exclusive-OR, swap, direction load and sleep
// Function
// - Literal minus accumulator: difference of literal and acc goes to acc.
// - Carry clear if acc above literal; nibble carry same on bits 3:0.
// - File minus accumulator: two's complement, updates carry, nibble carry, zero.
// - With borrow: also subtracts inverted carry; updates carry, nibble carry, zero.
// - Destination bit 0 writes accumulator, 1 writes the file register back.
// - Nibble exchange swaps halves of the file register; flags untouched.
// - Literal exclusive-OR into accumulator, only zero flag changes.
// - File exclusive-OR routed by destination bit, only zero flag changes.
// - Direction load copies acc to port A, B, C for operand 5, 6, 7.
// - Sleep clears the powerdown flag and sets the expiry flag.
// - Sleep clears watchdog counter to 00h and its prescaler.
// - After sleep updates, execution halts and the oscillator stops.
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "alu_ops_defines.svh"
module alu_exec_unit #(
  parameter int FILE_DEPTH = 128,
  parameter int PRESCALE_W = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [23:0] portDirection,
  output logic sleepMode,
  output logic oscRun
);
  import alu_ops_pkg::*;

  // ****************************************************************
  // State and registers
  // ****************************************************************
  exec_state_t state, next_state;
  opcode_t instrOp;
  logic instrDest;
  logic [7:0] instrArg;
  logic [7:0] acc;
  logic carry, nibbleCarry, zero, powerdown, expiry, sleeping;
  logic [7:0] watchdog;
  logic [PRESCALE_W-1:0] prescaler;
  logic [7:0] dirReg [3];
  logic [7:0] memRdata;
  logic memWe;
  logic [6:0] memWaddr, memRaddr;
  logic [7:0] memWdata;
  logic rdPending;
  logic [11:0] rdAddr;
  logic [31:0] readMux;

  alu_link_if link ();
  op_alu op_alu_inst (.link(link.alu));

  function automatic logic inFileWindow(input logic [11:0] a);
    return (a[11:9] == `FILE_WIN_TAG) && (a[1:0] == 2'h0);
  endfunction : inFileWindow

  // ****************************************************************
  // Bus write decode
  // ****************************************************************
  // Writes wait in idle so software never races an instruction in flight
  wire logic stIdle = (state == ST_IDLE);
  wire logic stQ3 = (state == ST_Q3);
  wire logic stQ4 = (state == ST_Q4);
  wire logic writeFire = awvalid && wvalid && !bvalid && stIdle;
  wire logic lane0 = wstrb[0];
  wire logic wrInstr = writeFire && (awaddr == `OFS_INSTR) && (wstrb[1:0] == 2'h3);
  wire logic wrAcc = writeFire && (awaddr == `OFS_ACC) && lane0;
  wire logic wrStatus = writeFire && (awaddr == `OFS_STATUS) && lane0;
  wire logic wrFile = writeFire && inFileWindow(awaddr) && lane0;
  wire logic [2:0] dirHitW;
  wire logic wrMapped = (awaddr == `OFS_INSTR) || (awaddr == `OFS_ACC) ||
                        (awaddr == `OFS_STATUS) || (awaddr == `OFS_WATCHDOG) ||
                        (|dirHitW) || inFileWindow(awaddr);
  // Sleeping core ignores new instructions until woken
  wire logic startExec = wrInstr && !sleeping;

  assign awready = writeFire;
  assign wready = writeFire;

  always_ff @(posedge clk) begin
    if (reset) begin
      bvalid <= 1'h0;
      bresp <= `RESP_OKAY;
    end else if (writeFire) begin
      bvalid <= 1'h1;
      bresp <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'h0;
    end
  end

  // ****************************************************************
  // Instruction sequencer
  // ****************************************************************
  // Four clocks per instruction cycle: read, settle, execute, retire
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: next_state = startExec ? ST_Q1 : ST_IDLE;
      ST_Q1: next_state = ST_Q2;
      ST_Q2: next_state = ST_Q3;
      ST_Q3: next_state = ST_Q4;
      ST_Q4: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= ST_IDLE;
      instrOp <= OP_NONE;
      instrDest <= 1'h0;
      instrArg <= 8'h00;
    end else begin
      state <= next_state;
      if (startExec) begin
        instrOp <= opcode_t'(wdata[`INSTR_OP_LSB +: 4]);
        instrDest <= wdata[`INSTR_DEST_BIT];
        instrArg <= wdata[7:0];
      end
    end
  end

  // ****************************************************************
  // Datapath and routing
  // ****************************************************************
  wire logic fileOp = isFileOp(instrOp);
  wire logic sleepExec = stQ3 && (instrOp == OP_SLEEP);
  wire logic accLoad = stQ3 && ((instrOp == OP_LITERAL_MINUS_ACC) ||
                       (instrOp == OP_LITERAL_XOR_ACC) || (fileOp && !instrDest));
  wire logic fileLoad = stQ3 && fileOp && instrDest;

  assign link.op = instrOp;
  assign link.acc = acc;
  assign link.operand = fileOp ? memRdata : instrArg;
  assign link.carryIn = carry;

  assign memWe = fileLoad || wrFile;
  assign memWaddr = fileLoad ? instrArg[6:0] : awaddr[8:2];
  assign memWdata = fileLoad ? link.result : wdata[7:0];
  assign memRaddr = stIdle ? araddr[8:2] : instrArg[6:0];

  file_reg_mem #(.WIDTH(8), .DEPTH(FILE_DEPTH), .AW(7)) file_reg_mem_inst (
    .clk(clk),
    .reset(reset),
    .writeEn(memWe),
    .writeAddr(memWaddr),
    .writeData(memWdata),
    .readAddr(memRaddr),
    .readData(memRdata)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      acc <= 8'h00;
    end else if (wrAcc) begin
      acc <= wdata[7:0];
    end else if (accLoad) begin
      acc <= link.result;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      carry <= 1'h0;
      nibbleCarry <= 1'h0;
      zero <= 1'h0;
    end else if (wrStatus) begin
      carry <= wdata[`ST_CARRY_BIT];
      nibbleCarry <= wdata[`ST_NIBBLE_BIT];
      zero <= wdata[`ST_ZERO_BIT];
    end else if (stQ3) begin
      if (link.updCarry) carry <= link.carryOut;
      if (link.updNibble) nibbleCarry <= link.nibbleOut;
      if (link.updZero) zero <= link.zeroOut;
    end
  end

  // ****************************************************************
  // Direction registers
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gDir
      assign dirHitW[g] = (awaddr == `OFS_DIR_BASE + 12'(4 * g));
      wire logic execHit = stQ3 && (instrOp == OP_DIRECTION_LOAD) &&
                           (instrArg == `DIR_OPERAND_FIRST + 8'(g));
      always_ff @(posedge clk) begin
        if (reset) begin
          dirReg[g] <= `RST_DIRECTION;
        end else if (execHit) begin
          dirReg[g] <= acc;
        end else if (writeFire && dirHitW[g] && lane0) begin
          dirReg[g] <= wdata[7:0];
        end
      end
      assign portDirection[8*g +: 8] = dirReg[g];
    end
  endgenerate

  // ****************************************************************
  // Sleep, power flags and watchdog
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      powerdown <= `RST_POWERDOWN;
      expiry <= `RST_EXPIRY;
      sleeping <= 1'h0;
    end else begin
      if (sleepExec) begin
        powerdown <= 1'h0;
        expiry <= 1'h1;
      end
      // Halt only once the flag and watchdog updates have landed
      if (stQ4 && (instrOp == OP_SLEEP)) begin
        sleeping <= 1'h1;
      end else if (wrStatus && wdata[`ST_WAKE_BIT]) begin
        sleeping <= 1'h0;
      end
    end
  end

  // Watchdog stands still with the oscillator during sleep
  always_ff @(posedge clk) begin
    if (reset || sleepExec) begin
      prescaler <= '0;
      watchdog <= `WDOG_CLEAR;
    end else if (!sleeping) begin
      prescaler <= prescaler + 1'h1;
      if (&prescaler) watchdog <= watchdog + 8'h01;
    end
  end

  assign sleepMode = sleeping;
  assign oscRun = !sleeping;

  // ****************************************************************
  // Bus read path
  // ****************************************************************
  // Uniform two-clock read latency hides the memory's registered output
  wire logic readFire = arvalid && !rvalid && !rdPending && stIdle;
  wire logic rdDir = (rdAddr[11:4] == 8'h01) && (rdAddr[3:2] != 2'h3) && (rdAddr[1:0] == 2'h0);
  wire logic [7:0] statusByte = {2'h0, sleeping, expiry, powerdown, zero, nibbleCarry, carry};
  wire logic rdMapped = (rdAddr == `OFS_INSTR) || (rdAddr == `OFS_ACC) ||
                        (rdAddr == `OFS_STATUS) || (rdAddr == `OFS_WATCHDOG) ||
                        rdDir || inFileWindow(rdAddr);
  assign arready = readFire;
  assign readMux = (rdAddr == `OFS_INSTR) ? {16'h0000, instrOp, 3'h0, instrDest, instrArg} :
                   (rdAddr == `OFS_ACC) ? {24'h000000, acc} :
                   (rdAddr == `OFS_STATUS) ? {24'h000000, statusByte} :
                   (rdAddr == `OFS_WATCHDOG) ? {24'h000000, watchdog} :
                   rdDir ? {24'h000000, dirReg[rdAddr[3:2]]} :
                   inFileWindow(rdAddr) ? {24'h000000, memRdata} : 32'h00000000;

  always_ff @(posedge clk) begin
    if (reset) begin
      rdPending <= 1'h0;
      rdAddr <= 12'h000;
      rvalid <= 1'h0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
    end else begin
      rdPending <= readFire;
      if (readFire) rdAddr <= araddr;
      if (rdPending) begin
        rvalid <= 1'h1;
        rdata <= readMux;
        rresp <= rdMapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'h0;
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_lit_sub_value: assert property (
    stQ3 && instrOp == OP_LITERAL_MINUS_ACC |=> acc == 8'(instrArg - $past(acc)))
    else $error("literal subtract result wrong");
  a_lit_sub_flags: assert property (
    stQ3 && instrOp == OP_LITERAL_MINUS_ACC |=> carry == (instrArg >= $past(acc)) &&
      nibbleCarry == (instrArg[3:0] >= $past(acc[3:0])))
    else $error("literal subtract flags wrong");
  a_file_sub_acc: assert property (
    stQ3 && instrOp == OP_FILE_MINUS_ACC && !instrDest |=>
      acc == 8'($past(memRdata) - $past(acc)) && carry == ($past(memRdata) >= $past(acc)))
    else $error("file subtract wrong");
  a_borrow_sub: assert property (
    stQ3 && instrOp == OP_FILE_MINUS_ACC_BORROW && !instrDest |=>
      acc == 8'($past(memRdata) - $past(acc) - 8'(!$past(carry))))
    else $error("borrow subtract wrong");
  a_dest_file: assert property (
    stQ3 && fileOp && instrDest |-> memWe && memWaddr == instrArg[6:0] && !accLoad)
    else $error("file destination not written");
  a_swap_flags: assert property (
    stQ3 && instrOp == OP_NIBBLE_EXCHANGE |=> $stable({carry, nibbleCarry, zero}))
    else $error("nibble exchange touched flags");
  a_xor_zero: assert property (
    stQ3 && instrOp == OP_LITERAL_XOR_ACC |=> zero == (acc == 8'h00) && $stable(carry))
    else $error("exclusive-OR zero flag wrong");
  a_dir_load: assert property (
    stQ3 && instrOp == OP_DIRECTION_LOAD && instrArg == 8'h06 |=>
      portDirection[15:8] == $past(acc))
    else $error("direction load missed");
  a_sleep_flags: assert property (
    sleepExec |=> !powerdown && expiry && watchdog == 8'h00)
    else $error("sleep flags or watchdog wrong");
  // Only the wake write may end a sleep
  a_sleep_halt: assert property (
    sleeping && stIdle && !(wrStatus && wdata[`ST_WAKE_BIT]) |=> stIdle && !oscRun)
    else $error("execution while sleeping");
  a_one_cycle: assert property (
    state == ST_Q1 |-> ##1 state == ST_Q2 ##1 stQ3 ##1 stQ4 ##1 stIdle)
    else $error("instruction cycle length wrong");
endmodule : alu_exec_unit
`default_nettype wire

// file: include/alu_ops_defines.svh
// Register offsets, field positions and reset values for the execution unit
`ifndef ALU_OPS_DEFINES_SVH
`define ALU_OPS_DEFINES_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_INSTR 12'h000
`define OFS_ACC 12'h004
`define OFS_STATUS 12'h008
`define OFS_WATCHDOG 12'h00C
`define OFS_DIR_BASE 12'h010
`define OFS_FILE_BASE 12'h200
`define FILE_WIN_TAG 3'h1

// ****************************************************************
// Field positions
// ****************************************************************
`define INSTR_DEST_BIT 8
`define INSTR_OP_LSB 12
`define ST_CARRY_BIT 0
`define ST_NIBBLE_BIT 1
`define ST_ZERO_BIT 2
`define ST_POWERDOWN_BIT 3
`define ST_EXPIRY_BIT 4
`define ST_SLEEP_BIT 5
`define ST_WAKE_BIT 7

// ****************************************************************
// Reset values and constants
// ****************************************************************
`define RST_DIRECTION 8'hFF
`define RST_POWERDOWN 1'h1
`define RST_EXPIRY 1'h1
`define DIR_OPERAND_FIRST 8'h05
`define WDOG_CLEAR 8'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: include/alu_ops_pkg.sv
// Types shared by the execution unit and its arithmetic core
package alu_ops_pkg;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_LITERAL_MINUS_ACC = 4'h1,
    OP_FILE_MINUS_ACC = 4'h2,
    OP_FILE_MINUS_ACC_BORROW = 4'h3,
    OP_NIBBLE_EXCHANGE = 4'h4,
    OP_LITERAL_XOR_ACC = 4'h5,
    OP_FILE_XOR_ACC = 4'h6,
    OP_DIRECTION_LOAD = 4'h7,
    OP_SLEEP = 4'h8
  } opcode_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_Q1 = 5'h02,
    ST_Q2 = 5'h04,
    ST_Q3 = 5'h08,
    ST_Q4 = 5'h10
  } exec_state_t;

  // Operations that read the addressed file register
  function automatic logic isFileOp(input opcode_t op);
    return (op == OP_FILE_MINUS_ACC) || (op == OP_FILE_MINUS_ACC_BORROW) ||
           (op == OP_NIBBLE_EXCHANGE) || (op == OP_FILE_XOR_ACC);
  endfunction : isFileOp

endpackage : alu_ops_pkg

// file: include/alu_link_if.sv
// Link between the sequencer and the arithmetic core
`timescale 1ns/1ps
`default_nettype none
interface alu_link_if;
  import alu_ops_pkg::*;
  opcode_t op;
  logic [7:0] acc;
  logic [7:0] operand;
  logic carryIn;
  logic [7:0] result;
  logic carryOut;
  logic nibbleOut;
  logic zeroOut;
  logic updCarry;
  logic updNibble;
  logic updZero;
  modport exec (output op, acc, operand, carryIn,
                input result, carryOut, nibbleOut, zeroOut, updCarry, updNibble, updZero);
  modport alu (input op, acc, operand, carryIn,
               output result, carryOut, nibbleOut, zeroOut, updCarry, updNibble, updZero);
endinterface : alu_link_if
`default_nettype wire

// file: core/file_reg_mem.sv
// File register memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module file_reg_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 128,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic writeEn,
  input wire logic [AW-1:0] writeAddr,
  input wire logic [WIDTH-1:0] writeData,
  input wire logic [AW-1:0] readAddr,
  output logic [WIDTH-1:0] readData
);
  // Contents are not cleared by reset, as in real data memory
  logic [WIDTH-1:0] store [DEPTH];

  always_ff @(posedge clk) begin
    if (writeEn) begin
      store[writeAddr] <= writeData;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      readData <= '0;
    end else begin
      readData <= store[readAddr];
    end
  end
endmodule : file_reg_mem
`default_nettype wire

// file: core/op_alu.sv
// Arithmetic core: subtract, exclusive-OR and nibble exchange
`timescale 1ns/1ps
`default_nettype none
module op_alu (
  alu_link_if.alu link
);
  import alu_ops_pkg::*;

  logic [7:0] invAcc;
  logic subCin;
  logic [8:0] subSum;
  logic [4:0] lowSum;
  logic isSub;
  logic isXor;

  // Borrow is the inverted carry, so carry itself is the add-in
  assign subCin = (link.op == OP_FILE_MINUS_ACC_BORROW) ? link.carryIn : 1'h1;
  assign invAcc = ~link.acc;
  // Two's complement subtract as operand plus inverted acc plus one
  assign subSum = {1'h0, link.operand} + {1'h0, invAcc} + {8'h00, subCin};
  assign lowSum = {1'h0, link.operand[3:0]} + {1'h0, invAcc[3:0]} + {4'h0, subCin};
  assign isSub = (link.op == OP_LITERAL_MINUS_ACC) || (link.op == OP_FILE_MINUS_ACC) ||
                 (link.op == OP_FILE_MINUS_ACC_BORROW);
  assign isXor = (link.op == OP_LITERAL_XOR_ACC) || (link.op == OP_FILE_XOR_ACC);

  assign link.result = isSub ? subSum[7:0] :
                       isXor ? (link.acc ^ link.operand) :
                       (link.op == OP_NIBBLE_EXCHANGE) ?
                         {link.operand[3:0], link.operand[7:4]} :
                       link.acc;
  assign link.carryOut = subSum[8];
  assign link.nibbleOut = lowSum[4];
  assign link.zeroOut = (link.result == 8'h00);
  assign link.updCarry = isSub;
  assign link.updNibble = isSub;
  assign link.updZero = isSub || isXor;
endmodule : op_alu
`default_nettype wire

// file: bench/alu_exec_unit_tb.sv
// Self-checking bench for the subtract, exclusive-OR, swap, direction and sleep unit
`timescale 1ns/1ps
`default_nettype none
module alu_exec_unit_tb;
  import alu_ops_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, sleepMode, oscRun;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd;
  logic [23:0] portDirection, dirE;
  logic [7:0] acc;
  logic [7:0] fm [0:127];
  logic c, dc, z, pd, ex, sl;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;

  alu_exec_unit #(.FILE_DEPTH(128), .PRESCALE_W(4)) alu_exec_unit_inst (
    .clk(clk), .reset(reset), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .portDirection(portDirection), .sleepMode(sleepMode), .oscRun(oscRun)
  );

  always #20 clk = ~clk;
  // Ceiling far above the roughly one thousand cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // ****************************************************************
  // Bus and comparison helpers
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic wrReg(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Ready is combinational, so it is judged mid-cycle before the taking edge
    do @(negedge clk); while (!(awready === 1'b1 && wready === 1'b1));
    @(posedge clk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(negedge clk); while (bvalid !== 1'b1);
    rsp = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask : wrReg

  task automatic rdReg(input logic [11:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask : rdReg

  task automatic setAcc(input logic [7:0] v);
    wrReg(12'h004, {24'h000000, v}, 4'h1);
    acc = v;
  endtask : setAcc

  task automatic setFile(input logic [6:0] f, input logic [7:0] v);
    wrReg(12'h200 + {f, 2'b00}, {24'h000000, v}, 4'h1);
    fm[f] = v;
  endtask : setFile

  task automatic setFlags(input logic [2:0] v);
    wrReg(12'h008, {29'h00000000, v}, 4'h1);
    {z, dc, c} = v;
  endtask : setFlags

  // ****************************************************************
  // Reference model and one-instruction runner
  // ****************************************************************
  task automatic model(input opcode_t op, input logic [7:0] k, input logic d);
    int m;
    int b;
    logic fo;
    logic [7:0] f;
    logic [7:0] r;
    // A sleeping core ignores instructions
    if (sl) return;
    f = fm[k[6:0]];
    m = (op == OP_LITERAL_MINUS_ACC) ? k : f;
    b = (op == OP_FILE_MINUS_ACC_BORROW) ? !c : 0;
    fo = op inside {OP_FILE_MINUS_ACC, OP_FILE_MINUS_ACC_BORROW, OP_NIBBLE_EXCHANGE,
                    OP_FILE_XOR_ACC};
    r = 8'h00;
    case (op)
      OP_LITERAL_MINUS_ACC, OP_FILE_MINUS_ACC, OP_FILE_MINUS_ACC_BORROW: begin
        r = 8'(m - acc - b);
        c = m >= acc + b;
        dc = m % 16 >= acc % 16 + b;
      end
      OP_NIBBLE_EXCHANGE: r = {f[3:0], f[7:4]};
      OP_LITERAL_XOR_ACC: r = acc ^ k;
      OP_FILE_XOR_ACC: r = acc ^ f;
      OP_DIRECTION_LOAD: if (k >= 5 && k <= 7) dirE[(k - 5) * 8 +: 8] = acc;
      OP_SLEEP: {pd, ex, sl} = 3'b011;
      default: ;
    endcase
    if (fo && op != OP_NIBBLE_EXCHANGE || op == OP_LITERAL_MINUS_ACC || op == OP_LITERAL_XOR_ACC)
      z = r == 8'h00;
    if (op == OP_LITERAL_MINUS_ACC || op == OP_LITERAL_XOR_ACC || (fo && !d)) acc = r;
    else if (fo) fm[k[6:0]] = r;
  endtask : model

  task automatic exec(input opcode_t op, input logic [7:0] k, input logic d);
    wrReg(12'h000, {16'h0000, op, 3'b000, d, k}, 4'h3);
    model(op, k, d);
    rdReg(12'h004);
    check(rd, {24'h000000, acc});
    rdReg(12'h008);
    check(rd & 32'h3F, {26'h0, sl, ex, pd, z, dc, c});
    rdReg(12'h200 + {k[6:0], 2'b00});
    check(rd, {24'h000000, fm[k[6:0]]});
    check({8'h00, portDirection}, {8'h00, dirE});
  endtask : exec

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_reset();
    rdReg(12'h008);
    check(rd & 32'h3F, 32'h00000018);
    check({oscRun, sleepMode, portDirection}, {2'b10, 24'hFFFFFF});
    for (int f = 0; f < 128; f++) setFile(f[6:0], 8'(f * 37));
  endtask : test_reset

  task automatic test_sub_literal();
    logic [15:0] t [5] = '{16'h0510, 16'h1010, 16'h1110, 16'h0F10, 16'h00FF};
    foreach (t[i]) begin
      setAcc(t[i][15:8]);
      exec(OP_LITERAL_MINUS_ACC, t[i][7:0], 1'b0);
    end
  endtask : test_sub_literal

  task automatic test_sub_file();
    // Equal operands with and without borrow hit the zero and wrap cases
    for (int i = 0; i < 8; i++) begin
      setFlags({2'b00, i[2]});
      setFile(7'h7F, 8'h22);
      setAcc(i[0] ? 8'h22 : 8'h13);
      exec(i[1] ? OP_FILE_MINUS_ACC_BORROW : OP_FILE_MINUS_ACC, 8'h7F, i[0]);
    end
  endtask : test_sub_file

  task automatic test_swap();
    setFlags(3'b101);
    setFile(7'h03, 8'hA5);
    exec(OP_NIBBLE_EXCHANGE, 8'h03, 1'b0);
    exec(OP_NIBBLE_EXCHANGE, 8'h03, 1'b1);
  endtask : test_swap

  task automatic test_xor();
    setFlags(3'b011);
    setAcc(8'h5A);
    exec(OP_LITERAL_XOR_ACC, 8'h5A, 1'b0);
    exec(OP_LITERAL_XOR_ACC, 8'hC3, 1'b0);
    setFile(7'h10, 8'h99);
    exec(OP_FILE_XOR_ACC, 8'h10, 1'b1);
    exec(OP_FILE_XOR_ACC, 8'h10, 1'b0);
  endtask : test_xor

  task automatic test_direction();
    for (int k = 4; k < 9; k++) begin
      setAcc(8'(k * 17));
      exec(OP_DIRECTION_LOAD, 8'(k), 1'b0);
    end
  endtask : test_direction

  task automatic test_sleep();
    setAcc(8'h3C);
    exec(OP_SLEEP, 8'h00, 1'b0);
    rdReg(12'h00C);
    check(rd, 32'h00000000);
    check({oscRun, sleepMode}, 32'h00000001);
    exec(OP_LITERAL_XOR_ACC, 8'hFF, 1'b0);
    wrReg(12'h008, {24'h000000, 5'b10000, z, dc, c}, 4'h1);
    sl = 1'b0;
    rdReg(12'h008);
    check(rd & 32'h3F, {26'h0, 3'b010, z, dc, c});
    check({oscRun, sleepMode}, 32'h00000002);
    wrReg(12'hFFC, 32'h00000000, 4'hF);
    check(rsp, 32'h00000002);
    rdReg(12'h0F0);
    check(rsp, 32'h00000002);
  endtask : test_sleep

  initial begin
    dirE = 24'hFFFFFF;
    {c, dc, z, pd, ex, sl} = 6'b000110;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    test_reset();
    test_sub_literal();
    test_sub_file();
    test_swap();
    test_xor();
    test_direction();
    test_sleep();
    give_verdict();
  end
endmodule : alu_exec_unit_tb
`default_nettype wire
